/* File: rtl/spu_pkg.sv */
/*
  Constants for the shaft position and usage counters.
  Assumes one 20 MHz clock and a synchronous active-high reset.

*/
package spu_pkg;
  // ============================================================
  // Timing
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned TICK_S         = 2;
  localparam int unsigned TICK_CYCLES    = CLK_HZ * TICK_S;
  localparam int unsigned TICKS_PER_DAY  = 43_200;
  localparam int unsigned TICKS_PER_HOUR = 1_800;
  localparam int unsigned HOURS_PER_KH   = 1_000;
  // ============================================================
  // Widths and reset values
  localparam int unsigned ANGLE_W        = 15;
  localparam int unsigned TOTAL_W        = 16;
  localparam int unsigned TURNS_W        = 32;
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 15'h0000;
  localparam logic [TOTAL_W-1:0] TOTAL_RST = 16'h0000;
  localparam logic [TURNS_W-1:0] TURNS_RST = 32'h0000_0000;
  // ============================================================
  // Index select codes and shaft revolution scale
  localparam logic [1:0] IDX_ENABLE  = 2'h1;
  localparam logic [1:0] IDX_DISABLE = 2'h2;
  localparam int unsigned SHAFT_REVS_PER_UNIT = 1_000_000;
endpackage

/* File: rtl/spu_angle.sv */
/*
  Shaft angle and signed turn counter, fed by encoder count strobes.
  Assumes encoder strobes already decoded and synchronous to CLK.
*/
`timescale 1ns/1ps
module spu_angle
  import spu_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               step_up,
  input  wire logic               step_dn,
  input  wire logic               zero,
  output logic [ANGLE_W-1:0]      angle,
  output logic [TURNS_W-1:0]      turns,
  output logic                    turn_done
);
  typedef struct packed {
    logic [ANGLE_W-1:0] angle;
    logic [TURNS_W-1:0] turns;
    logic               fwd_wrap;
  } spu_ang_t;
  spu_ang_t st, next_st;
  localparam logic [ANGLE_W-1:0] ANG_MAX = '1;

  always_comb begin
    next_st = st;
    next_st.fwd_wrap = 1'b0;
    if (zero) begin
      next_st.angle = ANGLE_RST;
    end else if (step_up && !step_dn) begin
      next_st.angle = st.angle + 15'h0001;
      if (st.angle == ANG_MAX) begin
        next_st.turns = st.turns + 32'h0000_0001;
        next_st.fwd_wrap = 1'b1;
      end
    end else if (step_dn && !step_up) begin
      next_st.angle = st.angle - 15'h0001;
      if (st.angle == ANGLE_RST) begin
        next_st.turns = st.turns - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign angle     = st.angle;
  assign turns     = st.turns;
  assign turn_done = st.fwd_wrap;

  // ============================================================
  // Checks
  a_fwd_wrap_inc: assert property (@(posedge clk) disable iff (rst)
    (!zero && step_up && !step_dn && angle == ANG_MAX) |=>
    (angle == ANGLE_RST && turns == $past(turns) + 32'h1))
    else $error("forward wrap did not increment turns");
  a_back_wrap_dec: assert property (@(posedge clk) disable iff (rst)
    (!zero && step_dn && !step_up && angle == ANGLE_RST) |=>
    (angle == ANG_MAX && turns == $past(turns) - 32'h1))
    else $error("backward wrap did not decrement turns");
  a_angle_step: assert property (@(posedge clk) disable iff (rst)
    (!zero && step_up && !step_dn) |=> angle == $past(angle) + 15'h1)
    else $error("angle did not step up");
  a_zero_angle: assert property (@(posedge clk) disable iff (rst)
    zero |=> angle == ANGLE_RST)
    else $error("angle not zeroed");
  a_turns_hold: assert property (@(posedge clk) disable iff (rst)
    (!step_up && !step_dn) |=> $stable(turns))
    else $error("turns changed without a step");
  c_fwd_wrap: cover property (@(posedge clk) disable iff (rst) turn_done);
  c_back_wrap: cover property (@(posedge clk) disable iff (rst)
    step_dn && !step_up && !zero && angle == ANGLE_RST);
endmodule // spu_angle

/* File: rtl/spu_counters.sv */
/*
  Usage counters (running time, energy, shaft turns, powered time) and
  the shaft-angle zeroing policy. Assumes energy pulses and encoder
  strobes are single-cycle and synchronous to CLK.
*/
`timescale 1ns/1ps
module spu_counters
  import spu_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   DRIVE_RUNNING,
  input  wire logic                   ENERGY_MWH_PULSE,
  input  wire logic                   MREV_PULSE,
  input  wire logic                   CLEAR_REQ,
  input  wire logic                   PARAM_MODE,
  input  wire logic                   ENC_UP,
  input  wire logic                   ENC_DN,
  input  wire logic                   ENC_INDEX,
  input  wire logic                   ENC_ENABLE,
  input  wire logic [1:0]             INDEX_PULSE_SELECT,
  input  wire logic                   ANGLE_ZERO_REQ,
  output logic [spu_pkg::TOTAL_W-1:0] RUN_TIME_TOTAL,
  output logic [spu_pkg::TOTAL_W-1:0] ENERGY_TOTAL,
  output logic [spu_pkg::TOTAL_W-1:0] SHAFT_TURN_TOTAL,
  output logic [spu_pkg::TOTAL_W-1:0] POWERED_DAYS,
  output logic [spu_pkg::TOTAL_W-1:0] POWERED_TICK_COUNT,
  output logic [spu_pkg::ANGLE_W-1:0] SHAFT_ANGLE,
  output logic [spu_pkg::TURNS_W-1:0] SIGNED_TURN_COUNT
);
  import spu_pkg::*;

  typedef struct packed {
    logic [31:0]        pre;       // Cycles into current 2 s tick
    logic [TOTAL_W-1:0] ticks;
    logic [TOTAL_W-1:0] days;
    logic [11:0]        run_ticks; // Running ticks within an hour
    logic [9:0]         run_hours; // Running hours within a kh
    logic [TOTAL_W-1:0] run_kh;
    logic [TOTAL_W-1:0] energy;
    logic [TOTAL_W-1:0] turns_m;
    logic [19:0]        rev_sub;   // Shaft revs within a million
    logic               enc_en_d;
    logic               enc_en_seen;
  } spu_state_t;

  spu_state_t st, next_st;
  logic       tick;
  logic       zero_angle;
  logic       fwd_turn;

  function automatic logic at_last(input logic [31:0] v,
                                   input int unsigned lim);
    return v == 32'(lim - 1);
  endfunction

  // ============================================================
  // Angle zeroing policy
  always_comb begin
    zero_angle = 1'b0;
    if (INDEX_PULSE_SELECT == IDX_ENABLE && ENC_INDEX)
      zero_angle = 1'b1;
    if (INDEX_PULSE_SELECT == IDX_DISABLE && ANGLE_ZERO_REQ)
      zero_angle = 1'b1;
    // First cycle after reset only captures the setting
    if (st.enc_en_seen && ENC_ENABLE != st.enc_en_d)
      zero_angle = 1'b1;
  end

  spu_angle u_angle (
    .clk       (CLK),
    .rst       (RST),
    .step_up   (ENC_UP),
    .step_dn   (ENC_DN),
    .zero      (zero_angle),
    .angle     (SHAFT_ANGLE),
    .turns     (SIGNED_TURN_COUNT),
    .turn_done (fwd_turn)
  );

  // ============================================================
  // Counters
  assign tick = at_last(st.pre, TICK_LEN);

  always_comb begin
    next_st = st;
    next_st.enc_en_d    = ENC_ENABLE;
    next_st.enc_en_seen = 1'b1;
    next_st.pre = tick ? 32'h0 : st.pre + 32'h1;
    if (tick) begin
      if (at_last({16'h0, st.ticks}, TICKS_PER_DAY)) begin
        next_st.ticks = TOTAL_RST;
        next_st.days  = st.days + 16'h0001;
      end else begin
        next_st.ticks = st.ticks + 16'h0001;
      end
      if (DRIVE_RUNNING) begin
        next_st.run_ticks = st.run_ticks + 12'h001;
        if (at_last({20'h0, st.run_ticks}, TICKS_PER_HOUR)) begin
          next_st.run_ticks = 12'h000;
          next_st.run_hours = st.run_hours + 10'h001;
          if (at_last({22'h0, st.run_hours}, HOURS_PER_KH)) begin
            next_st.run_hours = 10'h000;
            next_st.run_kh    = st.run_kh + 16'h0001;
          end
        end
      end
    end
    // Natural 16-bit overflow gives 65535 -> 0
    if (ENERGY_MWH_PULSE)
      next_st.energy = st.energy + 16'h0001;
    // Shaft revolutions come from forward wraps or an external pulse
    if (fwd_turn || MREV_PULSE) begin
      next_st.rev_sub = st.rev_sub + 20'h00001;
      if (at_last({12'h0, st.rev_sub}, SHAFT_REVS_PER_UNIT)) begin
        next_st.rev_sub = 20'h00000;
        next_st.turns_m = st.turns_m + 16'h0001;
      end
    end
    if (CLEAR_REQ && PARAM_MODE) begin
      next_st.turns_m = TOTAL_RST;
      next_st.rev_sub = 20'h00000;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RUN_TIME_TOTAL     = st.run_kh;
  assign ENERGY_TOTAL       = st.energy;
  assign SHAFT_TURN_TOTAL   = st.turns_m;
  assign POWERED_DAYS       = st.days;
  assign POWERED_TICK_COUNT = st.ticks;

  // ============================================================
  // Checks
  a_energy_wrap: assert property (@(posedge CLK) disable iff (RST)
    (ENERGY_MWH_PULSE && ENERGY_TOTAL == 16'hffff) |=>
    ENERGY_TOTAL == 16'h0000)
    else $error("energy total did not wrap to zero");
  a_turn_clear: assert property (@(posedge CLK) disable iff (RST)
    (CLEAR_REQ && PARAM_MODE) |=> SHAFT_TURN_TOTAL == 16'h0000)
    else $error("turn total not cleared");
  a_turn_noclear: assert property (@(posedge CLK) disable iff (RST)
    (!PARAM_MODE && !fwd_turn && !MREV_PULSE) |=> $stable(SHAFT_TURN_TOTAL))
    else $error("turn total changed outside parameter mode");
  a_days_stable: assert property (@(posedge CLK) disable iff (RST)
    !tick |=> $stable(POWERED_DAYS) && $stable(POWERED_TICK_COUNT))
    else $error("powered time moved without a tick");
  a_tick_step: assert property (@(posedge CLK) disable iff (RST)
    (tick && POWERED_TICK_COUNT != 16'(TICKS_PER_DAY - 1)) |=>
    POWERED_TICK_COUNT == $past(POWERED_TICK_COUNT) + 16'h1)
    else $error("tick count did not advance");
  a_run_hold: assert property (@(posedge CLK) disable iff (RST)
    !DRIVE_RUNNING |=> $stable(RUN_TIME_TOTAL))
    else $error("run time advanced while stopped");
  a_index_zero: assert property (@(posedge CLK) disable iff (RST)
    (INDEX_PULSE_SELECT == IDX_ENABLE && ENC_INDEX) |=>
    SHAFT_ANGLE == ANGLE_RST)
    else $error("index pulse did not zero angle");
  a_index_ignored: assert property (@(posedge CLK) disable iff (RST)
    (INDEX_PULSE_SELECT == IDX_DISABLE && !ANGLE_ZERO_REQ &&
     $stable(ENC_ENABLE) && !ENC_UP && !ENC_DN) |=> $stable(SHAFT_ANGLE))
    else $error("angle moved with index disabled");
  c_energy_wrap: cover property (@(posedge CLK) disable iff (RST)
    ENERGY_MWH_PULSE && ENERGY_TOTAL == 16'hffff);
  c_turn_clear: cover property (@(posedge CLK) disable iff (RST)
    CLEAR_REQ && PARAM_MODE);
  c_enable_flip: cover property (@(posedge CLK) disable iff (RST)
    $changed(ENC_ENABLE));
endmodule // spu_counters

/* File: bench/spu_enc_model.sv */
/*
  Incremental shaft encoder model: count strobes and an index pulse.
  Assumes callers enter its tasks just after a rising clk edge.
*/
`timescale 1ns/1ps
module spu_enc_model (
  input  wire logic clk,
  output logic      up,
  output logic      dn,
  output logic      index
);
  initial begin
    up    = 1'b0;
    dn    = 1'b0;
    index = 1'b0;
  end
  // ==========================================================
  // One strobe per edge, back to back, as a fast shaft would give
  task automatic move(input bit fwd, input int n);
    repeat (n) begin
      up = fwd;
      dn = !fwd;
      @(posedge clk);
      #1;
    end
    up = 1'b0;
    dn = 1'b0;
  endtask
  // Glitchy encoder: both strobes at once must not move the angle
  task automatic both_high();
    up = 1'b1;
    dn = 1'b1;
    @(posedge clk);
    #1;
    up = 1'b0;
    dn = 1'b0;
  endtask
  task automatic index_pulse();
    index = 1'b1;
    @(posedge clk);
    #1;
    index = 1'b0;
  endtask
endmodule // spu_enc_model

/* File: bench/tb_shaft_position_and_usage_counters.sv */
/*
  Self-checking bench for the usage counters and shaft angle.
  Assumes TICK_LEN shortened to 4 cycles; day, run-kilohour and million-rev counts are not run.
*/
`timescale 1ns/1ps
module tb_shaft_position_and_usage_counters;
  import spu_pkg::*;
  logic        CLK, RST, RUN, EPULSE, MREV, CLR, PMODE, ENA, ZREQ;
  logic        UP, DN, IDX;
  logic [1:0]  SEL;
  logic [15:0] RT, ET, ST, PD, PT;
  logic [14:0] ANG;
  logic [31:0] TRN;
  int          n_mismatch;
  int          samples_checked;
  spu_enc_model enc (.clk(CLK), .up(UP), .dn(DN), .index(IDX));
  spu_counters #(.TICK_LEN(4)) uut (
    .CLK(CLK), .RST(RST), .DRIVE_RUNNING(RUN), .ENERGY_MWH_PULSE(EPULSE),
    .MREV_PULSE(MREV), .CLEAR_REQ(CLR), .PARAM_MODE(PMODE),
    .ENC_UP(UP), .ENC_DN(DN), .ENC_INDEX(IDX), .ENC_ENABLE(ENA),
    .INDEX_PULSE_SELECT(SEL), .ANGLE_ZERO_REQ(ZREQ),
    .RUN_TIME_TOTAL(RT), .ENERGY_TOTAL(ET), .SHAFT_TURN_TOTAL(ST),
    .POWERED_DAYS(PD), .POWERED_TICK_COUNT(PT), .SHAFT_ANGLE(ANG),
    .SIGNED_TURN_COUNT(TRN));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // ==========================================================
  // Helpers
  task automatic cyc();
    @(posedge CLK);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_wrap();
    check(32'(ANG), 32'h0);
    check(TRN, 32'h0);
    enc.move(1'b0, 1);
    check(32'(ANG), 32'h7fff);
    check(TRN, 32'hffff_ffff);
    enc.move(1'b1, 1);
    check(32'(ANG), 32'h0);
    check(TRN, 32'h0);
    enc.move(1'b1, 5);
    enc.both_high();
    check(32'(ANG), 32'h5);
  endtask
  task automatic t_zeroing();
    SEL = IDX_DISABLE;
    enc.index_pulse();
    check(32'(ANG), 32'h5);
    ZREQ = 1'b1;
    cyc();
    ZREQ = 1'b0;
    cyc();
    check(32'(ANG), 32'h0);
    enc.move(1'b1, 3);
    SEL = IDX_ENABLE;
    ZREQ = 1'b1;
    cyc();
    ZREQ = 1'b0;
    cyc();
    check(32'(ANG), 32'h3);
    enc.index_pulse();
    check(32'(ANG), 32'h0);
    enc.move(1'b1, 7);
    ENA = 1'b0;
    cyc();
    check(32'(ANG), 32'h0);
    enc.move(1'b1, 2);
    ENA = 1'b1;
    cyc();
    check(32'(ANG), 32'h0);
    check(TRN, 32'h0);
  endtask
  task automatic t_energy();
    EPULSE = 1'b1;
    repeat (65535) cyc();
    EPULSE = 1'b0;
    check(32'(ET), 32'h0000_ffff);
    EPULSE = 1'b1;
    cyc();
    EPULSE = 1'b0;
    check(32'(ET), 32'h0);
  endtask
  task automatic t_ticks();
    logic [15:0] t0;
    // Clear attempts must not touch the powered-time or run-time totals
    CLR   = 1'b1;
    PMODE = 1'b1;
    cyc();
    CLR   = 1'b0;
    PMODE = 1'b0;
    t0 = PT;
    repeat (40) cyc();
    check(32'(PT), 32'(t0 + 16'h000a));
    check(32'(PD), 32'h0);
    check(32'(RT), 32'h0);
    check(32'(ST), 32'h0);
  endtask
  task automatic t_reset();
    enc.move(1'b1, 3);
    check(32'(ANG), 32'h3);
    RST = 1'b1;
    cyc();
    RST = 1'b0;
    cyc();
    check(32'(ANG), 32'h0);
    check(TRN, 32'h0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    {RST, RUN, EPULSE, MREV, CLR, PMODE, ZREQ} = 7'h40;
    ENA = 1'b1;
    SEL = IDX_ENABLE;
    repeat (6) cyc();
    RST = 1'b0;
    RUN = 1'b1;
    cyc();
    t_wrap();
    t_zeroing();
    t_energy();
    t_ticks();
    t_reset();
    print_verdict();
  end
  initial begin
    #5_000_000;
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_shaft_position_and_usage_counters
